// ### src/tmr_timer3.sv
// Timer 3 control, counter, reload, overflow flags and capture
//
// Behaviour
// - High overflow flag set on high byte wrap
// - In 16-bit mode, set on full wrap
// - Set high flag requests interrupt when enabled
// - Flags cleared only by software writing zero
// - Low flag set on every low byte wrap
// - Low flag interrupts when low enable set
// - Capture copies count to reload on oscillator fall
// - Split bit selects one 16-bit or two 8-bit
// - Run bit gates counting; split: high byte only
// - Split low byte counts regardless of run
// - Select: sys/12, ext/8, reserved, oscillator/8
// - Ext and oscillator sources synchronised to clock
// - One select feeds both bytes in split
// - Per-byte override to undivided system clock
// - 16-bit wrap loads reload value into counter
// - Split wraps reload each byte from own reload
`timescale 1ns/100ps
`default_nettype none
module tmr_timer3
   import tmr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [7:0] sfrAddr,
   input  wire logic       sfrWe,
   input  wire logic [7:0] sfrWdata,
   output logic      [7:0] sfrRdata,
   input  wire logic       extClkPin,
   input  wire logic       lfoPin,
   input  wire logic       highByteFastClock,
   input  wire logic       lowByteFastClock,
   input  wire logic       extendedIrqEnable,
   output logic            irqReq
);
   logic [7:0]  ctrl_reg,   ctrl_next;
   logic [15:0] count_reg,  count_next;
   logic [15:0] reload_reg, reload_next;
   logic [3:0]  pre_reg,    pre_next;
   logic [2:0]  extDiv_reg, extDiv_next;
   logic [2:0]  lfoDiv_reg, lfoDiv_next;
   logic [7:0]  rdata_reg,  rdata_next;
   logic        irq_reg,    irq_next;
   logic        extRise, lfoRise, lfoFall;
   logic        sysTick, extTick, lfoTick, altTick;
   logic        lowTick, highTick, lowAdv, highAdv;
   logic        lowWrap, highWrap, splitMode;
   logic        wrCtrl, capHit;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   tmr_sync_edge extSync (
      .core_clk (core_clk),
      .rst      (rst),
      .asyncIn  (extClkPin),
      .riseP    (extRise),
      .fallP    ()
   );
   tmr_sync_edge lfoSync (
      .core_clk (core_clk),
      .rst      (rst),
      .asyncIn  (lfoPin),
      .riseP    (lfoRise),
      .fallP    (lfoFall)
   );

   // ---------------------------------------------------------------
   // Prescalers
   // ---------------------------------------------------------------
   localparam logic [3:0] PRE_LAST = 4'(SYS_DIVIDE - 1);
   localparam logic [2:0] ALT_LAST = 3'(ALT_DIVIDE - 1);

   // Prescaler width is fixed; larger divides would wrap early
   if (SYS_DIVIDE < 2 || SYS_DIVIDE > 16) begin : gSysDivCheck
      $error("system divide does not fit the prescaler");
   end
   // Alternate divider relies on its three-bit count wrapping
   if (ALT_DIVIDE != 8) begin : gAltDivCheck
      $error("alternate divide must be eight");
   end

   always_comb begin
      sysTick     = (pre_reg == PRE_LAST);
      pre_next    = sysTick ? 4'h0 : pre_reg + 4'h1;
      extTick     = extRise && (extDiv_reg == ALT_LAST);
      lfoTick     = lfoRise && (lfoDiv_reg == ALT_LAST);
      extDiv_next = extRise ? extDiv_reg + 3'h1 : extDiv_reg;
      lfoDiv_next = lfoRise ? lfoDiv_reg + 3'h1 : lfoDiv_reg;
      // Reserved setting gives no alternate-source ticks; only the fast overrides step
      case (tmr_src_e'(ctrl_reg[SEL_MSB:SEL_LSB]))
         TMR_SRC_SYS_DIV12: altTick = sysTick;
         TMR_SRC_EXT_DIV8:  altTick = extTick;
         TMR_SRC_LFO_DIV8:  altTick = lfoTick;
         default:           altTick = 1'b0;
      endcase
      lowTick  = lowByteFastClock  ? 1'b1 : altTick;
      highTick = highByteFastClock ? 1'b1 : altTick;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pre_reg    <= 4'h0;
         extDiv_reg <= 3'h0;
         lfoDiv_reg <= 3'h0;
      end else begin
         pre_reg    <= pre_next;
         extDiv_reg <= extDiv_next;
         lfoDiv_reg <= lfoDiv_next;
      end
   end

   // ---------------------------------------------------------------
   // Step decode and capture
   // ---------------------------------------------------------------
   always_comb begin
      splitMode = ctrl_reg[BIT_SPLIT];
      wrCtrl    = sfrWe && (sfrAddr == ADDR_CONTROL);
      capHit    = ctrl_reg[BIT_CAPTURE_EN] && lfoFall;
      if (splitMode) begin
         lowAdv  = lowTick;
         highAdv = ctrl_reg[BIT_RUN] && highTick;
      end else begin
         // Whole word steps on the low byte's clock
         lowAdv  = ctrl_reg[BIT_RUN] && lowTick;
         highAdv = lowAdv && (count_reg[7:0] == BYTE_MAX);
      end
      lowWrap  = lowAdv && (count_reg[7:0] == BYTE_MAX);
      highWrap = highAdv && (count_reg[15:8] == BYTE_MAX);
   end

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_comb begin
      count_next = count_reg;
      if (splitMode) begin
         count_next[7:0]  = lowWrap ? reload_reg[7:0]
                          : count_reg[7:0] + {7'h00, lowAdv};
         count_next[15:8] = highWrap ? reload_reg[15:8]
                          : count_reg[15:8] + {7'h00, highAdv};
      end else if (lowAdv) begin
         count_next = (count_reg == WORD_MAX) ? reload_reg
                    : count_reg + 16'h0001;
      end
      // Software write takes the byte over any step
      if (sfrWe && sfrAddr == ADDR_COUNT_LOW)
         count_next[7:0] = sfrWdata;
      if (sfrWe && sfrAddr == ADDR_COUNT_HIGH)
         count_next[15:8] = sfrWdata;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= RESET_WORD;
      end else begin
         count_reg <= count_next;
      end
   end

   // ---------------------------------------------------------------
   // Reload pair
   // ---------------------------------------------------------------
   always_comb begin
      reload_next = reload_reg;
      if (sfrWe && sfrAddr == ADDR_RELOAD_LOW)
         reload_next[7:0] = sfrWdata;
      if (sfrWe && sfrAddr == ADDR_RELOAD_HIGH)
         reload_next[15:8] = sfrWdata;
      // Capture beats a same-cycle software write to reload
      if (capHit)
         reload_next = count_reg;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reload_reg <= RESET_WORD;
      end else begin
         reload_reg <= reload_next;
      end
   end

   // ---------------------------------------------------------------
   // Control register and flags
   // ---------------------------------------------------------------
   always_comb begin
      ctrl_next = wrCtrl ? sfrWdata : ctrl_reg;
      // Hardware set wins over a software clear
      if (highWrap || capHit)
         ctrl_next[BIT_HIGH_FLAG] = 1'b1;
      if (lowWrap)
         ctrl_next[BIT_LOW_FLAG] = 1'b1;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_reg <= RESET_BYTE;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt request and read data
   // ---------------------------------------------------------------
   // Both registered, so the processor never sees decode glitches
   always_comb begin
      irq_next = extendedIrqEnable && (ctrl_reg[BIT_HIGH_FLAG]
               || (ctrl_reg[BIT_LOW_FLAG]
                   && ctrl_reg[BIT_LOW_IRQEN]));

      case (sfrAddr)
         ADDR_CONTROL:     rdata_next = ctrl_reg;
         ADDR_RELOAD_LOW:  rdata_next = reload_reg[7:0];
         ADDR_RELOAD_HIGH: rdata_next = reload_reg[15:8];
         ADDR_COUNT_LOW:   rdata_next = count_reg[7:0];
         ADDR_COUNT_HIGH:  rdata_next = count_reg[15:8];
         default:          rdata_next = RESET_BYTE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_reg <= RESET_BYTE;
         irq_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
      end
   end

   assign sfrRdata = rdata_reg;
   assign irqReq   = irq_reg;
endmodule : tmr_timer3
`default_nettype wire

// ### src/tmr_pkg.sv
// Package of constants for the timer 3 control block
package tmr_pkg;
   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL     = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LOW   = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h95;

   // ---------------------------------------------------------------
   // Control field positions and reset values
   // ---------------------------------------------------------------
   localparam int BIT_HIGH_FLAG  = 7;
   localparam int BIT_LOW_FLAG   = 6;
   localparam int BIT_LOW_IRQEN  = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT      = 3;
   localparam int BIT_RUN        = 2;
   localparam int SEL_MSB        = 1;
   localparam int SEL_LSB        = 0;
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [7:0]  BYTE_MAX   = 8'hFF;
   localparam logic [15:0] WORD_MAX   = 16'hFFFF;

   // ---------------------------------------------------------------
   // Alternate clock source encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TMR_SRC_SYS_DIV12 = 2'h0,
      TMR_SRC_EXT_DIV8  = 2'h1,
      TMR_SRC_RESERVED  = 2'h2,
      TMR_SRC_LFO_DIV8  = 2'h3
   } tmr_src_e;

   localparam int SYS_DIVIDE = 12;
   localparam int ALT_DIVIDE = 8;
endpackage : tmr_pkg

// ### src/tmr_sync_edge.sv
// Two-flop synchroniser with edge pulses for one asynchronous pin
`timescale 1ns/100ps
`default_nettype none
module tmr_sync_edge (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic asyncIn,
   output logic      riseP,
   output logic      fallP
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // ---------------------------------------------------------------
   // Synchroniser; only sync_reg reads meta_reg
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign riseP = sync_reg & ~last_reg;
   assign fallP = ~sync_reg & last_reg;
endmodule : tmr_sync_edge
`default_nettype wire

// ### dv/tmr_timer3_props.sv
// Port checks for the timer 3 control block
`timescale 1ns/100ps
`default_nettype none
module tmr_timer3_props
   import tmr_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [7:0] sfrAddr,
   input wire logic       sfrWe,
   input wire logic [7:0] sfrWdata,
   input wire logic [7:0] sfrRdata,
   input wire logic       extendedIrqEnable,
   input wire logic       irqReq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   reset_out_a: assert property (disable iff (1'b0)
      rst |=> !irqReq && sfrRdata == 8'h00) else $error("reset output");
   unmapped_zero_a: assert property (sfrAddr < ADDR_CONTROL ||
      sfrAddr > ADDR_COUNT_HIGH |=> sfrRdata == 8'h00)
      else $error("unmapped read");
   ctl_back_a: assert property (
      sfrWe && sfrAddr == ADDR_CONTROL ##1 !sfrWe && sfrAddr == ADDR_CONTROL
      |=> sfrRdata[5:0] == $past(sfrWdata[5:0], 2)) else $error("ctl bits");
   flags_sticky_a: assert property (
      !$past(sfrWe) && sfrAddr == ADDR_CONTROL && $past(sfrAddr) == 8'h91
      |=> (sfrRdata[7:6] & $past(sfrRdata[7:6])) == $past(sfrRdata[7:6]))
      else $error("flag fell");
   irq_high_a: assert property (
      $past(sfrAddr) == ADDR_CONTROL && !$past(sfrWe) && sfrRdata[7] &&
      extendedIrqEnable |=> irqReq) else $error("high irq");
   irq_low_a: assert property (
      $past(sfrAddr) == ADDR_CONTROL && !$past(sfrWe) && sfrRdata[6] &&
      sfrRdata[5] && extendedIrqEnable |=> irqReq) else $error("low irq");
   irq_masked_a: assert property (
      !extendedIrqEnable |=> !irqReq) else $error("irq masked");
   irq_cause_a: assert property (
      $rose(irqReq) |-> $past(extendedIrqEnable)) else $error("irq rise");
endmodule : tmr_timer3_props
bind tmr_timer3 tmr_timer3_props u_props (.core_clk(core_clk), .rst(rst),
   .sfrAddr(sfrAddr), .sfrWe(sfrWe), .sfrWdata(sfrWdata),
   .sfrRdata(sfrRdata), .extendedIrqEnable(extendedIrqEnable),
   .irqReq(irqReq));
`default_nettype wire

// ### dv/test_tmr_timer3.sv
// Self-checking bench for the timer 3 control block
`timescale 1ns/100ps
`default_nettype none
module test_tmr_timer3 import tmr_pkg::*;;
   logic       core_clk = 1'b0, rst = 1'b1, sfrWe = 1'b0, irqReq;
   logic       extClkPin = 1'b0, lfoPin = 1'b0, hiF = 1'b0, loF = 1'b0;
   logic       irqEn = 1'b1;
   logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
   logic [7:0] cntA, cntB;
   int         n_errors = 0, compares = 0;
   tmr_timer3 DUT (.core_clk(core_clk), .rst(rst), .sfrAddr(sfrAddr),
      .sfrWe(sfrWe), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
      .extClkPin(extClkPin), .lfoPin(lfoPin), .highByteFastClock(hiF),
      .lowByteFastClock(loF), .extendedIrqEnable(irqEn), .irqReq(irqReq));
   initial forever #20 core_clk = ~core_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sfrAddr <= a;
      sfrWe <= 1'b1;
      sfrWdata <= d;
      @(posedge core_clk);
      sfrWe <= 1'b0;
   endtask : wr
   // Read data lags the address by one edge
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      sfrAddr <= a;
      @(posedge core_clk);
      #1 chk(sfrRdata, exp);
   endtask : rc
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      sfrAddr <= a;
      @(posedge core_clk);
      #1 d = sfrRdata;
   endtask : rd
   task automatic tick(input logic h, input logic l, input int n);
      @(posedge core_clk);
      hiF <= h;
      loF <= l;
      repeat (n) @(posedge core_clk);
      hiF <= 1'b0;
      loF <= 1'b0;
   endtask : tick
   // Slow pulses so the synchroniser sees every edge
   task automatic pins(input int n);
      repeat (n) begin
         @(posedge core_clk);
         extClkPin <= 1'b1;
         lfoPin <= 1'b1;
         repeat (3) @(posedge core_clk);
         extClkPin <= 1'b0;
         lfoPin <= 1'b0;
         repeat (5) @(posedge core_clk);
      end
   endtask : pins
   task automatic give_verdict();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (10000) @(posedge core_clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      for (int a = 'h90; a < 'h97; a++)
         rc(8'(a), 8'h00);
      wr(ADDR_CONTROL, 8'h2B);
      wr(8'h96, 8'hFF);
      rc(ADDR_CONTROL, 8'h2B);
      rc(8'h96, 8'h00);
      $display("registers done");
      wr(ADDR_COUNT_LOW, 8'hFE);
      wr(ADDR_COUNT_HIGH, 8'hFE);
      wr(ADDR_RELOAD_LOW, 8'h40);
      wr(ADDR_RELOAD_HIGH, 8'h80);
      wr(ADDR_CONTROL, 8'h0A);
      tick(1'b1, 1'b1, 3);
      rc(ADDR_COUNT_LOW, 8'h41);
      rc(ADDR_COUNT_HIGH, 8'hFE);
      rc(ADDR_CONTROL, 8'h4A);
      chk({7'h00, irqReq}, 8'h00);
      wr(ADDR_CONTROL, 8'h0E);
      tick(1'b1, 1'b0, 3);
      rc(ADDR_COUNT_HIGH, 8'h81);
      rc(ADDR_CONTROL, 8'h8E);
      chk({7'h00, irqReq}, 8'h01);
      @(posedge core_clk);
      irqEn <= 1'b0;
      rc(ADDR_COUNT_LOW, 8'h41);
      chk({7'h00, irqReq}, 8'h00);
      @(posedge core_clk);
      irqEn <= 1'b1;
      $display("split done");
      wr(ADDR_CONTROL, 8'h02);
      wr(ADDR_COUNT_LOW, 8'hFE);
      wr(ADDR_COUNT_HIGH, 8'hFF);
      wr(ADDR_RELOAD_LOW, 8'h34);
      wr(ADDR_RELOAD_HIGH, 8'h12);
      tick(1'b0, 1'b1, 3);
      rc(ADDR_COUNT_LOW, 8'hFE);
      wr(ADDR_CONTROL, 8'h26);
      tick(1'b0, 1'b1, 3);
      rc(ADDR_COUNT_LOW, 8'h35);
      rc(ADDR_COUNT_HIGH, 8'h12);
      rc(ADDR_CONTROL, 8'hE6);
      $display("word done");
      wr(ADDR_CONTROL, 8'h60);
      rc(ADDR_CONTROL, 8'h60);
      chk({7'h00, irqReq}, 8'h01);
      wr(ADDR_CONTROL, 8'h40);
      rc(ADDR_CONTROL, 8'h40);
      chk({7'h00, irqReq}, 8'h00);
      // Sys/12: two reads 120 edges apart see exactly ten steps
      wr(ADDR_CONTROL, 8'h04);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      rd(ADDR_COUNT_LOW, cntA);
      repeat (118) @(posedge core_clk);
      rd(ADDR_COUNT_LOW, cntB);
      chk(8'(cntB - cntA), 8'h0A);
      for (int s = 1; s < 4; s++) begin
         wr(ADDR_CONTROL, 8'h04 | 8'(s));
         wr(ADDR_COUNT_LOW, 8'h00);
         wr(ADDR_COUNT_HIGH, 8'h00);
         pins(16);
         rc(ADDR_COUNT_LOW, (s == 2) ? 8'h00 : 8'h02);
      end
      wr(ADDR_CONTROL, 8'h0D);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      pins(8);
      rc(ADDR_COUNT_LOW, 8'h01);
      rc(ADDR_COUNT_HIGH, 8'h01);
      $display("sources done");
      wr(ADDR_CONTROL, 8'h16);
      wr(ADDR_COUNT_LOW, 8'h78);
      wr(ADDR_COUNT_HIGH, 8'h56);
      pins(1);
      rc(ADDR_RELOAD_LOW, 8'h78);
      rc(ADDR_RELOAD_HIGH, 8'h56);
      rc(ADDR_CONTROL, 8'h96);
      chk({7'h00, irqReq}, 8'h01);
      $display("capture done");
      give_verdict();
   end
endmodule : test_tmr_timer3
`default_nettype wire
